// file: tcx_core.sv
/*
 * Execution of thread enter/exit, idle and byte/word increment,
 * with an APB register port for issue, pointers, flags and status.
 * Assumes MEM_RDATA answers the address on MEM_ADDR in the same cycle
 * as MEM_RD, and that IRQ comes from outside the clock domain.
 */
// Operation
// - enter: sp minus two, push thread_pointer
// - enter: thread_pointer takes program counter
// - enter: pc from code word, pointer plus two
// - exit: pop thread_pointer, sp plus two
// - exit: pc from code word, pointer plus two
// - exit opcode 2F, 14 or 16 cycles
// - idle opcode 6F halts cpu clock
// - interrupt or reset ends idle
// - byte increment, four cycles, three forms
// - indirect form increments addressed register
// - z s v from result; c d h kept
// - word_plus_one_op: 16-bit even pair, eight cycles
`include "tcx_map.svh"
module tcx_core (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic IRQ,
    input wire logic [7:0] MEM_RDATA,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic MEM_PROG,
    output logic [15:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic CPU_HALT
);
    tcx_pkg::tcx_state_s s_r;
    tcx_pkg::tcx_state_s s_nxt;
    logic irq_s;
    logic acc_w;
    logic start_w;
    logic ir_w;
    logic word_w;
    logic [4:0] k_w;
    logic [7:0] a0_raw;
    logic [7:0] a0_w;
    logic [15:0] inc_res;
    logic inc_z;
    logic inc_s;
    logic inc_v;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic tcx_pkg::tcx_op_e dec(input logic [7:0] c);
        tcx_pkg::tcx_op_e o;
        o = tcx_pkg::OP_BAD;
        if (c == `TCX_OPC_ENTER) o = tcx_pkg::OP_ENTER;
        else if (c == `TCX_OPC_EXIT) o = tcx_pkg::OP_EXIT;
        else if (c == `TCX_OPC_IDLE) o = tcx_pkg::OP_IDLE;
        else if (c == `TCX_OPC_INC_RG) o = tcx_pkg::OP_INC_RG;
        else if (c == `TCX_OPC_INC_IR) o = tcx_pkg::OP_INC_IR;
        else if (c == `TCX_OPC_WORD_PLUS_ONE_OP_RR) o = tcx_pkg::OP_WORD_PLUS_ONE_OP_RR;
        else if (c == `TCX_OPC_WORD_PLUS_ONE_OP_IR) o = tcx_pkg::OP_WORD_PLUS_ONE_OP_IR;
        else if (c[3:0] == `TCX_OPC_INC_R_LO) o = tcx_pkg::OP_INC_RG;
        return o;
    endfunction : dec

    function automatic logic [4:0] budget(input tcx_pkg::tcx_op_e o, input logic ext);
        logic [4:0] n;
        n = `TCX_CYC_BAD;
        unique case (o)
            tcx_pkg::OP_ENTER: n = `TCX_CYC_ENTER;
            tcx_pkg::OP_EXIT: n = ext ? `TCX_CYC_EXIT_EXT : `TCX_CYC_EXIT;
            tcx_pkg::OP_IDLE: n = `TCX_CYC_IDLE;
            tcx_pkg::OP_INC_RG, tcx_pkg::OP_INC_IR: n = `TCX_CYC_INC;
            tcx_pkg::OP_WORD_PLUS_ONE_OP_RR, tcx_pkg::OP_WORD_PLUS_ONE_OP_IR: n = `TCX_CYC_WORD_PLUS_ONE_OP;
            tcx_pkg::OP_BAD: n = `TCX_CYC_BAD;
        endcase
        return n;
    endfunction : budget

    // working-register escape maps onto the working bank
    function automatic logic [7:0] res_adr(input logic [7:0] b, input logic [7:0] wrb);
        return (b[7:4] == `TCX_WREG_HI) ? {wrb[7:4], b[3:0]} : b;
    endfunction : res_adr

    ////////////////////////////////////////////////////////////////////
    // datapath pieces

    tcx_sync u_irq_sync (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .d(IRQ),
        .q(irq_s)
    );

    assign ir_w = (s_r.op == tcx_pkg::OP_INC_IR) || (s_r.op == tcx_pkg::OP_WORD_PLUS_ONE_OP_IR);
    assign word_w = (s_r.op == tcx_pkg::OP_WORD_PLUS_ONE_OP_RR) || (s_r.op == tcx_pkg::OP_WORD_PLUS_ONE_OP_IR);
    assign k_w = s_r.cyc - {4'h0, ir_w};
    assign a0_raw = ir_w ? MEM_RDATA : res_adr(s_r.opnd, s_r.wrb);
    assign a0_w = word_w ? {a0_raw[7:1], 1'b0} : a0_raw;

    tcx_inc u_inc (
        .word(word_w),
        .val(word_w ? {s_r.tmp, MEM_RDATA} : {8'h00, MEM_RDATA}),
        .res(inc_res),
        .zero(inc_z),
        .neg(inc_s),
        .ovf(inc_v)
    );

    assign acc_w = PSEL && PENABLE && s_r.pready;
    assign start_w = acc_w && PWRITE && (PADDR == `TCX_ADR_ISSUE) && !s_r.busy && !s_r.idle;

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_nxt = s_r;
        s_nxt.mrd = 1'b0;
        s_nxt.mwr = 1'b0;
        s_nxt.mprog = 1'b0;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (s_r.busy) begin
            s_nxt.cyc = s_r.cyc + 5'h01;
            unique case (s_r.op)
                tcx_pkg::OP_ENTER: begin
                    case (s_r.cyc)
                        5'h00: begin
                            s_nxt.sp = s_r.sp - `TCX_STK_STEP;
                            s_nxt.mwr = 1'b1;
                            s_nxt.maddr = s_r.sp - `TCX_STK_STEP;
                            s_nxt.mwdata = s_r.tptr[15:8];
                        end
                        5'h01: begin
                            s_nxt.mwr = 1'b1;
                            s_nxt.maddr = s_r.sp + `TCX_BYTE_NEXT;
                            s_nxt.mwdata = s_r.tptr[7:0];
                        end
                        5'h02: begin
                            s_nxt.tptr = s_r.pc;
                            s_nxt.mrd = 1'b1;
                            s_nxt.mprog = 1'b1;
                            s_nxt.maddr = s_r.pc;
                        end
                        5'h03: begin
                            s_nxt.tmp = MEM_RDATA;
                            s_nxt.mrd = 1'b1;
                            s_nxt.mprog = 1'b1;
                            s_nxt.maddr = s_r.tptr + `TCX_BYTE_NEXT;
                        end
                        5'h04: begin
                            s_nxt.pc = {s_r.tmp, MEM_RDATA};
                            s_nxt.tptr = s_r.tptr + `TCX_TPTR_STEP;
                        end
                        default: begin
                        end
                    endcase
                end
                tcx_pkg::OP_EXIT: begin
                    case (s_r.cyc)
                        5'h00: begin
                            s_nxt.mrd = 1'b1;
                            s_nxt.maddr = s_r.sp;
                        end
                        5'h01: begin
                            s_nxt.tmp = MEM_RDATA;
                            s_nxt.mrd = 1'b1;
                            s_nxt.maddr = s_r.sp + `TCX_BYTE_NEXT;
                        end
                        5'h02: begin
                            s_nxt.tptr = {s_r.tmp, MEM_RDATA};
                            s_nxt.sp = s_r.sp + `TCX_STK_STEP;
                            s_nxt.mrd = 1'b1;
                            s_nxt.mprog = 1'b1;
                            s_nxt.maddr = {s_r.tmp, MEM_RDATA};
                        end
                        5'h03: begin
                            s_nxt.tmp = MEM_RDATA;
                            s_nxt.mrd = 1'b1;
                            s_nxt.mprog = 1'b1;
                            s_nxt.maddr = s_r.tptr + `TCX_BYTE_NEXT;
                        end
                        5'h04: begin
                            s_nxt.pc = {s_r.tmp, MEM_RDATA};
                            s_nxt.tptr = s_r.tptr + `TCX_TPTR_STEP;
                        end
                        default: begin
                        end
                    endcase
                end
                tcx_pkg::OP_IDLE, tcx_pkg::OP_BAD: begin
                end
                tcx_pkg::OP_INC_RG, tcx_pkg::OP_INC_IR,
                tcx_pkg::OP_WORD_PLUS_ONE_OP_RR, tcx_pkg::OP_WORD_PLUS_ONE_OP_IR: begin
                    if (ir_w && (s_r.cyc == 5'h00)) begin
                        s_nxt.mrd = 1'b1;
                        s_nxt.maddr = {8'h00, res_adr(s_r.opnd, s_r.wrb)};
                    end
                    if (k_w == 5'h00) begin
                        s_nxt.ptr = a0_w;
                        s_nxt.mrd = 1'b1;
                        s_nxt.maddr = {8'h00, a0_w};
                    end
                    if (k_w == 5'h01) begin
                        if (!word_w) begin
                            s_nxt.mwr = 1'b1;
                            s_nxt.maddr = {8'h00, s_r.ptr};
                            s_nxt.mwdata = inc_res[7:0];
                            s_nxt.flags[`TCX_FLG_Z] = inc_z;
                            s_nxt.flags[`TCX_FLG_S] = inc_s;
                            s_nxt.flags[`TCX_FLG_V] = inc_v;
                        end else begin
                            s_nxt.tmp = MEM_RDATA;
                            s_nxt.mrd = 1'b1;
                            s_nxt.maddr = {8'h00, s_r.ptr[7:1], 1'b1};
                        end
                    end
                    if (word_w && (k_w == 5'h02)) begin
                        s_nxt.mwr = 1'b1;
                        s_nxt.maddr = {8'h00, s_r.ptr[7:1], 1'b1};
                        s_nxt.mwdata = inc_res[7:0];
                        s_nxt.tmp = inc_res[15:8];
                        s_nxt.flags[`TCX_FLG_Z] = inc_z;
                        s_nxt.flags[`TCX_FLG_S] = inc_s;
                        s_nxt.flags[`TCX_FLG_V] = inc_v;
                    end
                    if (word_w && (k_w == 5'h03)) begin
                        s_nxt.mwr = 1'b1;
                        s_nxt.maddr = {8'h00, s_r.ptr};
                        s_nxt.mwdata = s_r.tmp;
                    end
                end
            endcase
            if (s_r.cyc == budget(s_r.op, s_r.ext) - 5'h01) begin
                s_nxt.busy = 1'b0;
                s_nxt.idle = (s_r.op == tcx_pkg::OP_IDLE);
            end
        end else if (s_r.idle && irq_s) begin
            s_nxt.idle = 1'b0;
        end
        // apb slave: answer in the access cycle after setup
        if (PSEL && !PENABLE) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0000_0000;
            case (PADDR)
                `TCX_ADR_ISSUE: s_nxt.prdata = {16'h0000, s_r.opnd, 4'h0, s_r.op};
                `TCX_ADR_STATUS: begin
                    s_nxt.prdata[`TCX_ST_BUSY] = s_r.busy;
                    s_nxt.prdata[`TCX_ST_IDLE] = s_r.idle;
                    s_nxt.prdata[`TCX_ST_BAD] = s_r.bad;
                end
                `TCX_ADR_PC: s_nxt.prdata = {16'h0000, s_r.pc};
                `TCX_ADR_TPTR: s_nxt.prdata = {16'h0000, s_r.tptr};
                `TCX_ADR_SP: s_nxt.prdata = {16'h0000, s_r.sp};
                `TCX_ADR_FLAGS: s_nxt.prdata = {24'h000000, s_r.flags};
                `TCX_ADR_CFG: begin
                    s_nxt.prdata[7:0] = s_r.wrb;
                    s_nxt.prdata[`TCX_CFG_EXT] = s_r.ext;
                end
                default: s_nxt.pslverr = 1'b1;
            endcase
        end
        if (acc_w && PWRITE && !s_r.busy) begin
            case (PADDR)
                `TCX_ADR_ISSUE: begin
                    if (start_w) begin
                        s_nxt.busy = 1'b1;
                        s_nxt.cyc = 5'h00;
                        s_nxt.op = dec(PWDATA[`TCX_ISSUE_OPC]);
                        s_nxt.bad = (dec(PWDATA[`TCX_ISSUE_OPC]) == tcx_pkg::OP_BAD);
                        s_nxt.opnd = PWDATA[`TCX_ISSUE_OPND];
                        if (PWDATA[3:0] == `TCX_OPC_INC_R_LO) begin
                            s_nxt.opnd = {`TCX_WREG_HI, PWDATA[7:4]};
                        end
                    end
                end
                `TCX_ADR_PC: s_nxt.pc = PWDATA[15:0];
                `TCX_ADR_TPTR: s_nxt.tptr = PWDATA[15:0];
                `TCX_ADR_SP: s_nxt.sp = PWDATA[15:0];
                `TCX_ADR_FLAGS: s_nxt.flags = PWDATA[7:0];
                `TCX_ADR_CFG: begin
                    s_nxt.wrb = PWDATA[7:0];
                    s_nxt.ext = PWDATA[`TCX_CFG_EXT];
                end
                default: begin
                end
            endcase
        end
        s_nxt.halt = s_nxt.idle;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r <= '0;
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign MEM_RD = s_r.mrd;
    assign MEM_WR = s_r.mwr;
    assign MEM_PROG = s_r.mprog;
    assign MEM_ADDR = s_r.maddr;
    assign MEM_WDATA = s_r.mwdata;
    assign CPU_HALT = s_r.halt;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST || !CE);

    sequence s_issue(logic [7:0] opc);
        start_w && (PWDATA[`TCX_ISSUE_OPC] == opc);
    endsequence

    sequence s_step(tcx_pkg::tcx_op_e o, logic [4:0] c);
        s_r.busy && (s_r.op == o) && (s_r.cyc == c);
    endsequence

    property p_enter_push;
        s_step(tcx_pkg::OP_ENTER, 5'h01) |->
            MEM_WR && (MEM_ADDR == s_r.sp) && (s_r.sp == $past(s_r.sp) - `TCX_STK_STEP)
            && (MEM_WDATA == s_r.tptr[15:8]);
    endproperty
    a_enter_push: assert property (p_enter_push) else $error("enter push wrong");

    property p_enter_tptr;
        s_step(tcx_pkg::OP_ENTER, 5'h02) |=> s_r.tptr == $past(s_r.pc);
    endproperty
    a_enter_tptr: assert property (p_enter_tptr) else $error("enter pointer copy wrong");

    property p_enter_pc;
        s_step(tcx_pkg::OP_ENTER, 5'h04) |=>
            (s_r.pc == {$past(s_r.tmp), $past(MEM_RDATA)})
            && (s_r.tptr == $past(s_r.tptr) + `TCX_TPTR_STEP);
    endproperty
    a_enter_pc: assert property (p_enter_pc) else $error("enter pc load wrong");

    property p_exit_pop;
        s_step(tcx_pkg::OP_EXIT, 5'h02) |=>
            (s_r.sp == $past(s_r.sp) + `TCX_STK_STEP)
            && (s_r.tptr == {$past(s_r.tmp), $past(MEM_RDATA)});
    endproperty
    a_exit_pop: assert property (p_exit_pop) else $error("exit pop wrong");

    property p_exit_len;
        s_issue(`TCX_OPC_EXIT) and !s_r.ext |-> ##14 s_r.busy ##1 !s_r.busy;
    endproperty
    a_exit_len: assert property (p_exit_len) else $error("exit length wrong");

    property p_idle_len;
        s_issue(`TCX_OPC_IDLE) |-> ##4 s_r.busy ##1 (!s_r.busy && s_r.idle && CPU_HALT);
    endproperty
    a_idle_len: assert property (p_idle_len) else $error("idle entry wrong");

    property p_idle_wake;
        s_r.idle && !s_r.busy && irq_s |=> !s_r.idle && !CPU_HALT;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not released");

    property p_inc_ir;
        s_step(tcx_pkg::OP_INC_IR, 5'h01) |=>
            MEM_RD && (MEM_ADDR == {8'h00, $past(MEM_RDATA)})
            ##1 MEM_WR && (MEM_ADDR == $past(MEM_ADDR));
    endproperty
    a_inc_ir: assert property (p_inc_ir) else $error("indirect target wrong");

    property p_inc_flags;
        s_step(tcx_pkg::OP_INC_RG, 5'h01) |=>
            (s_r.flags[`TCX_FLG_Z] == ($past(MEM_RDATA) == 8'hFF))
            && (s_r.flags[`TCX_FLG_V] == ($past(MEM_RDATA) == 8'h7F));
    endproperty
    a_inc_flags: assert property (p_inc_flags) else $error("byte flags wrong");

    property p_keep_cdh;
        s_r.busy |=> (s_r.flags[`TCX_FLG_C] == $past(s_r.flags[`TCX_FLG_C]))
            && (s_r.flags[`TCX_FLG_D] == $past(s_r.flags[`TCX_FLG_D]))
            && (s_r.flags[`TCX_FLG_H] == $past(s_r.flags[`TCX_FLG_H]));
    endproperty
    a_keep_cdh: assert property (p_keep_cdh) else $error("c d h flags changed");

    property p_word_plus_one_op_len;
        s_issue(`TCX_OPC_WORD_PLUS_ONE_OP_RR) |-> ##8 s_r.busy ##1 !s_r.busy;
    endproperty
    a_word_plus_one_op_len: assert property (p_word_plus_one_op_len) else $error("word increment length wrong");

    property p_word_plus_one_op_carry;
        s_step(tcx_pkg::OP_WORD_PLUS_ONE_OP_RR, 5'h02) |=>
            (s_r.tmp == (($past(MEM_RDATA) == 8'hFF) ? $past(s_r.tmp) + 8'h01 : $past(s_r.tmp)));
    endproperty
    a_word_plus_one_op_carry: assert property (p_word_plus_one_op_carry) else $error("carry lost");

    property p_enter_len;
        s_issue(`TCX_OPC_ENTER) |-> ##14 s_r.busy ##1 !s_r.busy;
    endproperty
    a_enter_len: assert property (p_enter_len) else $error("enter length wrong");

    property p_exit_len_ext;
        s_issue(`TCX_OPC_EXIT) and s_r.ext |-> ##16 s_r.busy ##1 !s_r.busy;
    endproperty
    a_exit_len_ext: assert property (p_exit_len_ext) else $error("slow exit length wrong");

    property p_inc_len;
        s_issue(`TCX_OPC_INC_RG) |-> ##4 s_r.busy ##1 !s_r.busy;
    endproperty
    a_inc_len: assert property (p_inc_len) else $error("byte increment length wrong");

endmodule : tcx_core

// file: tcx_core_tb.sv
/*
 * Self-checking bench of the execution core over APB.
 * Assumes the memory model answers the core's strobes.
 */
module tcx_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, mem_rd, mem_wr, mem_prog, cpu_halt;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata;
    int n_fail = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    tcx_core uut (.CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IRQ(irq), .MEM_RDATA(mem_rdata), .MEM_RD(mem_rd),
        .MEM_WR(mem_wr), .MEM_PROG(mem_prog), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .CPU_HALT(cpu_halt));
    tcx_mem_model mem (.CLK(clk), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_PROG(mem_prog),
        .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata));
    ////////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    task run(input logic [7:0] opc, input logic [7:0] opnd);
        int i;
        apb(1'b1, 8'h00, {16'h0, opnd, opc});
        for (i = 0; i < 40; i++) begin
            apb(1'b0, 8'h04, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        if (i == 40) begin
            n_fail++;
            complete_run();
        end
    endtask : run
    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rchk(8'h08, 32'h0);
        rchk(8'h10, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 32'h1);
        run(8'h00, 8'h00);
        rchk(8'h04, 32'h4);
    endtask : t_reset
    task t_inc;
        mem.regs[5] = 8'h7F;
        apb(1'b1, 8'h14, 32'h8C);
        run(8'h20, 8'h05);
        chk(mem.regs[5], 32'h80);
        rchk(8'h14, 32'hBC);
        apb(1'b1, 8'h18, 32'hC0);
        mem.regs[8'hC3] = 8'hFF;
        run(8'h3E, 8'h00);
        chk(mem.regs[8'hC3], 32'h0);
        rchk(8'h14, 32'hCC);
        mem.regs[8'h10] = 8'h20;
        mem.regs[8'h20] = 8'h0F;
        run(8'h21, 8'h10);
        chk(mem.regs[8'h20], 32'h10);
        rchk(8'h14, 32'h8C);
    endtask : t_inc
    task t_word_plus_one_op;
        mem.regs[2] = 8'h0F;
        mem.regs[3] = 8'hFF;
        run(8'hA0, 8'h02);
        chk({mem.regs[2], mem.regs[3]}, 32'h1000);
        mem.regs[6] = 8'hFF;
        mem.regs[7] = 8'hFF;
        run(8'hA0, 8'h06);
        chk(mem.regs[6] | mem.regs[7], 32'h0);
        mem.regs[8'h11] = 8'h04;
        mem.regs[4] = 8'h7F;
        mem.regs[5] = 8'hFF;
        run(8'hA1, 8'h11);
        chk({mem.regs[4], mem.regs[5]}, 32'h8000);
        rchk(8'h14, 32'hBC);
    endtask : t_word_plus_one_op
    task t_thread;
        apb(1'b1, 8'h08, 32'h40);
        apb(1'b1, 8'h0C, 32'h80);
        apb(1'b1, 8'h10, 32'hF0);
        mem.prog[8'h40] = 8'h12;
        mem.prog[8'h41] = 8'h34;
        mem.prog[8'h80] = 8'h56;
        mem.prog[8'h81] = 8'h78;
        run(8'h1F, 8'h00);
        rchk(8'h10, 32'hEE);
        chk({mem.regs[8'hEE], mem.regs[8'hEF]}, 32'h80);
        rchk(8'h0C, 32'h42);
        rchk(8'h08, 32'h1234);
        rchk(8'h14, 32'hBC);
        run(8'h2F, 8'h00);
        rchk(8'h0C, 32'h82);
        rchk(8'h10, 32'hF0);
        rchk(8'h08, 32'h5678);
        apb(1'b1, 8'h18, 32'h100);
        apb(1'b1, 8'h10, 32'hEE);
        run(8'h2F, 8'h00);
        rchk(8'h0C, 32'h82);
        rchk(8'h14, 32'hBC);
    endtask : t_thread
    task t_idle;
        int i;
        run(8'h6F, 8'h00);
        chk(cpu_halt, 32'h1);
        rchk(8'h04, 32'h2);
        irq <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            if (cpu_halt === 1'b0) break;
        end
        chk(i < 8, 32'h1);
        irq <= 1'b0;
        run(8'h6F, 8'h00);
        chk(cpu_halt, 32'h1);
        rst <= 1'b1;
        @(posedge clk);
        chk(cpu_halt, 32'h0);
        rst <= 1'b0;
        @(posedge clk);
        rchk(8'h04, 32'h0);
    endtask : t_idle
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_inc();
        t_word_plus_one_op();
        t_thread();
        t_idle();
        complete_run();
    end
endmodule : tcx_core_tb

// file: tcx_inc.sv
/*
 * Byte or word plus-one with zero, sign and overflow results.
 * Assumes the caller places a byte in the low half of val.
 */
`include "tcx_map.svh"
module tcx_inc (
    input wire logic word,
    input wire logic [15:0] val,
    output logic [15:0] res,
    output logic zero,
    output logic neg,
    output logic ovf
);
    logic [15:0] sum;

    // carry of the low byte runs into the high byte
    assign sum = val + `TCX_BYTE_NEXT;
    assign res = word ? sum : {8'h00, sum[7:0]};
    assign zero = word ? (sum == 16'h0000) : (sum[7:0] == 8'h00);
    assign neg = word ? sum[15] : sum[7];
    assign ovf = word ? (sum == 16'h8000) : (sum[7:0] == 8'h80);
endmodule : tcx_inc

// file: tcx_map.svh
/*
 * Constant map of the threaded-code / idle / increment execution block:
 * opcodes, cycle budgets, register offsets, bit positions.
 * Assumes inclusion by bare name from every file that needs a number.
 */
`ifndef TCX_MAP_SVH
`define TCX_MAP_SVH

// opcodes
`define TCX_OPC_ENTER 8'h1F
`define TCX_OPC_EXIT 8'h2F
`define TCX_OPC_IDLE 8'h6F
`define TCX_OPC_INC_RG 8'h20
`define TCX_OPC_INC_IR 8'h21
`define TCX_OPC_WORD_PLUS_ONE_OP_RR 8'hA0
`define TCX_OPC_WORD_PLUS_ONE_OP_IR 8'hA1
`define TCX_OPC_INC_R_LO 4'hE
`define TCX_WREG_HI 4'hE

// cycle budgets
`define TCX_CYC_ENTER 5'h0E
`define TCX_CYC_EXIT 5'h0E
`define TCX_CYC_EXIT_EXT 5'h10
`define TCX_CYC_IDLE 5'h04
`define TCX_CYC_INC 5'h04
`define TCX_CYC_WORD_PLUS_ONE_OP 5'h08
`define TCX_CYC_BAD 5'h01

// pointer steps
`define TCX_STK_STEP 16'h0002
`define TCX_TPTR_STEP 16'h0002
`define TCX_BYTE_NEXT 16'h0001

// apb register offsets
`define TCX_ADR_ISSUE 8'h00
`define TCX_ADR_STATUS 8'h04
`define TCX_ADR_PC 8'h08
`define TCX_ADR_TPTR 8'h0C
`define TCX_ADR_SP 8'h10
`define TCX_ADR_FLAGS 8'h14
`define TCX_ADR_CFG 8'h18

// field positions
`define TCX_FLG_C 7
`define TCX_FLG_Z 6
`define TCX_FLG_S 5
`define TCX_FLG_V 4
`define TCX_FLG_D 3
`define TCX_FLG_H 2
`define TCX_ST_BUSY 0
`define TCX_ST_IDLE 1
`define TCX_ST_BAD 2
`define TCX_CFG_EXT 8
`define TCX_ISSUE_OPC 7:0
`define TCX_ISSUE_OPND 15:8

`endif

// file: tcx_mem_model.sv
/*
 * Far-side model: program memory plus register file and stack.
 * Assumes reads answered in the strobe cycle, writes land on the edge.
 */
module tcx_mem_model (
    input wire logic CLK,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic MEM_PROG,
    input wire logic [15:0] MEM_ADDR,
    input wire logic [7:0] MEM_WDATA,
    output logic [7:0] MEM_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] prog [0:255];
    logic [7:0] regs [0:255];
    logic [7:0] junk = 8'h5A;
    // bus toggles while nothing is read
    always @(posedge CLK) begin
        junk <= ~junk;
        if (MEM_WR && !MEM_PROG) begin
            regs[MEM_ADDR[7:0]] <= MEM_WDATA;
        end
    end
    assign MEM_RDATA = !MEM_RD ? junk : MEM_PROG ? prog[MEM_ADDR[7:0]] : regs[MEM_ADDR[7:0]];
endmodule : tcx_mem_model

// file: tcx_pkg.sv
/*
 * Types of the execution block: instruction classes and state records.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tcx_pkg;

    typedef enum logic [3:0] {
        OP_ENTER   = 4'b0000,
        OP_EXIT    = 4'b0001,
        OP_IDLE    = 4'b0010,
        OP_INC_RG  = 4'b0011,
        OP_INC_IR  = 4'b0100,
        OP_WORD_PLUS_ONE_OP_RR = 4'b0101,
        OP_WORD_PLUS_ONE_OP_IR = 4'b0110,
        OP_BAD     = 4'b0111
    } tcx_op_e;

    typedef struct packed {
        logic busy;
        tcx_op_e op;
        logic [4:0] cyc;
        logic [7:0] opnd;
        logic [7:0] ptr;
        logic [7:0] tmp;
        logic [15:0] pc;
        logic [15:0] tptr;
        logic [15:0] sp;
        logic [7:0] flags;
        logic [7:0] wrb;
        logic ext;
        logic idle;
        logic halt;
        logic bad;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic mrd;
        logic mwr;
        logic mprog;
        logic [15:0] maddr;
        logic [7:0] mwdata;
    } tcx_state_s;

    typedef struct packed {
        logic ff1;
        logic ff2;
    } tcx_sync_s;

endpackage : tcx_pkg

// file: tcx_sync.sv
/*
 * Two-flop synchroniser for a level from outside the clock domain.
 * Assumes clk, async active-high rst and a clock enable from the core.
 */
module tcx_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    tcx_pkg::tcx_sync_s s_r;
    tcx_pkg::tcx_sync_s s_nxt;

    always_comb begin
        s_nxt.ff1 = d;
        s_nxt.ff2 = s_r.ff1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.ff2;
endmodule : tcx_sync
